// ==== shared/ffsm_pkg.sv ====
// Register map, reset values and modulator encodings for the spread modulator
package ffsm_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SPREAD_ENA_PER_HI = 8'h10;
    localparam logic [7:0] IDX_SPREAD_PER_LO     = 8'h11;
    localparam logic [7:0] IDX_FB_INTEGER        = 8'h12;
    localparam logic [7:0] IDX_FB_FRAC_HI        = 8'h13;
    localparam logic [7:0] IDX_FB_FRAC_LO        = 8'h14;
    localparam logic [7:0] IDX_SPREAD_STEP_HI    = 8'h15;
    localparam logic [7:0] IDX_SPREAD_STEP_LO    = 8'h16;
    localparam logic [7:0] IDX_OUT_DIV_LO        = 8'h21;
    localparam logic [7:0] IDX_OUT_DIV_HI        = 8'h22;
    localparam logic [7:0] IDX_REF_CTRL          = 8'h25;
    localparam logic [7:0] IDX_STATUS            = 8'h30;
    localparam int         ADDR_LSB              = 2;

    // Field positions
    localparam int SPREAD_ENA_BIT  = 7;
    localparam int DOUBLER_ENA_BIT = 5;
    localparam int BYTE_W          = 8;
    localparam int FRAC_PAD_W      = 8;   // Step resolution is 2^-24, fraction 2^-16

    // Reset values (default down-spread configuration)
    localparam logic [7:0]  RST_SPREAD_ENA_PER_HI = 8'h81;
    localparam logic [7:0]  RST_SPREAD_PER_LO     = 8'h8D;
    localparam logic [7:0]  RST_FB_INTEGER        = 8'h19;
    localparam logic [15:0] RST_FB_FRAC           = 16'h0000;
    localparam logic [15:0] RST_SPREAD_STEP       = 16'h0A42;
    localparam logic [11:0] RST_OUT_DIV           = 12'h019;
    localparam logic [7:0]  RST_REF_CTRL          = 8'h6D;

    // Output divider floor
    localparam logic [11:0] OUT_DIV_MIN = 12'h008;

    // Modulator states, Gray coded along idle -> down -> up -> down
    typedef enum logic [1:0] {
        FFSM_IDLE = 2'b00,
        FFSM_DOWN = 2'b01,
        FFSM_UP   = 2'b11
    } ffsm_state_t;
endpackage : ffsm_pkg

// ==== hdl/ffsm_modulator.sv ====
// Fractional feedback divider control with triangle spread modulation and APB registers

module ffsm_modulator
    import ffsm_pkg::*;
#(
    parameter int CNT_W = 13      // Half-ramp tick counter width
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Feedback divider output, one pulse per divider cycle
    input  wire logic        fb_tick,
    // Controls toward the analog loop
    output logic [7:0]       divide_whole_part,
    output logic [23:0]      divide_fractional_part,
    output logic [32:0]      fb_total_divide,
    output logic             doubler_enable,
    output logic [11:0]      out_divide,
    output logic             spread_active
);
    // Register storage
    logic [7:0]  ena_per_hi_q, ena_per_hi_d;   // Enable bit and period [11:8]
    logic [7:0]  per_lo_q,     per_lo_d;       // Period [7:0]
    logic [7:0]  fb_int_q,     fb_int_d;       // Whole part of divide value
    logic [15:0] fb_frac_q,    fb_frac_d;      // Fraction of divide value
    logic [15:0] step_q,       step_d;         // Modulation step
    logic [11:0] odiv_q,       odiv_d;         // Output divider setting
    logic [7:0]  ref_ctrl_q,   ref_ctrl_d;     // Reference control byte
    // Bus answer registers
    logic [31:0] rdata_q,      rdata_d;
    logic        ready_q,      ready_d;
    logic        err_q,        err_d;
    // Modulator state
    ffsm_state_t             st_q,   st_d;
    logic [CNT_W-1:0]        cnt_q,  cnt_d;    // Ticks spent in current ramp
    logic [31:0]             ofs_q,  ofs_d;    // Offset below programmed value
    logic [7:0]              whole_q, whole_d;
    logic [23:0]             frac_q,  frac_d;
    logic [32:0]             total_q, total_d;
    logic                    dbl_q,   dbl_d;
    logic [11:0]             odo_q,   odo_d;
    logic                    act_q,   act_d;   // Modulator running, kept in its own flop

    // True for any index that holds a register
    function automatic logic idx_mapped(input logic [7:0] idx);
        case (idx)
            IDX_SPREAD_ENA_PER_HI, IDX_SPREAD_PER_LO, IDX_FB_INTEGER,
            IDX_FB_FRAC_HI, IDX_FB_FRAC_LO, IDX_SPREAD_STEP_HI,
            IDX_SPREAD_STEP_LO, IDX_OUT_DIV_LO, IDX_OUT_DIV_HI,
            IDX_REF_CTRL, IDX_STATUS: idx_mapped = 1'b1;
            default:                  idx_mapped = 1'b0;
        endcase
    endfunction : idx_mapped

    // Word index from byte address; low bits ignored
    logic [7:0] acc_idx;
    logic       addr_ok;
    logic       acc_phase;
    logic       wr_fire;
    assign acc_idx   = paddr[ADDR_LSB +: BYTE_W];
    assign addr_ok   = idx_mapped(acc_idx) && (paddr[11:10] == 2'b00);
    assign acc_phase = psel && penable;
    assign wr_fire   = acc_phase && ready_q && pwrite && addr_ok;

    // Full programmed value, whole.frac at 2^-24 resolution
    logic [31:0] p_full;
    logic [31:0] step_ext;
    logic [CNT_W-1:0] half_len;
    assign p_full   = {fb_int_q, fb_frac_q, {FRAC_PAD_W{1'b0}}};
    assign step_ext = {{(32-16){1'b0}}, step_q};
    // Register holds a quarter cycle, so each ramp lasts twice its value
    assign half_len = CNT_W'({ena_per_hi_q[3:0], per_lo_q, 1'b0});

    // Register file next values and bus answer
    always_comb begin
        ena_per_hi_d = ena_per_hi_q;
        per_lo_d     = per_lo_q;
        fb_int_d     = fb_int_q;
        fb_frac_d    = fb_frac_q;
        step_d       = step_q;
        odiv_d       = odiv_q;
        ref_ctrl_d   = ref_ctrl_q;
        rdata_d      = rdata_q;
        err_d        = 1'b0;
        // One wait state: answer registered, ready the cycle after
        ready_d      = acc_phase && !ready_q;
        if (acc_phase && !ready_q) begin
            err_d   = !addr_ok;
            rdata_d = '0;
            case (acc_idx)
                IDX_SPREAD_ENA_PER_HI: rdata_d[7:0] = ena_per_hi_q;
                IDX_SPREAD_PER_LO:     rdata_d[7:0] = per_lo_q;
                IDX_FB_INTEGER:        rdata_d[7:0] = fb_int_q;
                IDX_FB_FRAC_HI:        rdata_d[7:0] = fb_frac_q[15:8];
                IDX_FB_FRAC_LO:        rdata_d[7:0] = fb_frac_q[7:0];
                IDX_SPREAD_STEP_HI:    rdata_d[7:0] = step_q[15:8];
                IDX_SPREAD_STEP_LO:    rdata_d[7:0] = step_q[7:0];
                IDX_OUT_DIV_LO:        rdata_d[7:0] = odiv_q[7:0];
                IDX_OUT_DIV_HI:        rdata_d[7:0] = {odiv_q[11:8], 4'h0};
                IDX_REF_CTRL:          rdata_d[7:0] = ref_ctrl_q;
                IDX_STATUS:            rdata_d[7:0] = {6'h00, st_q};
                default:               rdata_d      = '0;
            endcase
            if (!addr_ok) begin
                rdata_d = '0;
            end
        end
        if (wr_fire) begin
            case (acc_idx)
                IDX_SPREAD_ENA_PER_HI: ena_per_hi_d    = pwdata[7:0];
                IDX_SPREAD_PER_LO:     per_lo_d        = pwdata[7:0];
                IDX_FB_INTEGER:        fb_int_d        = pwdata[7:0];
                IDX_FB_FRAC_HI:        fb_frac_d[15:8] = pwdata[7:0];
                IDX_FB_FRAC_LO:        fb_frac_d[7:0]  = pwdata[7:0];
                IDX_SPREAD_STEP_HI:    step_d[15:8]    = pwdata[7:0];
                IDX_SPREAD_STEP_LO:    step_d[7:0]     = pwdata[7:0];
                IDX_OUT_DIV_LO:        odiv_d[7:0]     = pwdata[7:0];
                IDX_OUT_DIV_HI:        odiv_d[11:8]    = pwdata[7:4];
                IDX_REF_CTRL:          ref_ctrl_d      = pwdata[7:0];
                default:               ref_ctrl_d      = ref_ctrl_q;    // Status is read only
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ena_per_hi_q <= RST_SPREAD_ENA_PER_HI;
            per_lo_q     <= RST_SPREAD_PER_LO;
            fb_int_q     <= RST_FB_INTEGER;
            fb_frac_q    <= RST_FB_FRAC;
            step_q       <= RST_SPREAD_STEP;
            odiv_q       <= RST_OUT_DIV;
            ref_ctrl_q   <= RST_REF_CTRL;
            rdata_q      <= '0;
            ready_q      <= 1'b0;
            err_q        <= 1'b0;
        end else begin
            ena_per_hi_q <= ena_per_hi_d;
            per_lo_q     <= per_lo_d;
            fb_int_q     <= fb_int_d;
            fb_frac_q    <= fb_frac_d;
            step_q       <= step_d;
            odiv_q       <= odiv_d;
            ref_ctrl_q   <= ref_ctrl_d;
            rdata_q      <= rdata_d;
            ready_q      <= ready_d;
            err_q        <= err_d;
        end
    end

    // Triangle modulator and loop controls
    always_comb begin
        logic [31:0] mod_val;
        logic        ramp_end;
        mod_val  = '0;
        ramp_end = 1'b0;
        st_d     = st_q;
        cnt_d    = cnt_q;
        ofs_d    = ofs_q;
        // Zero length still reverses every tick rather than stalling
        ramp_end = (cnt_q + CNT_W'(1) >= half_len);
        if (!ena_per_hi_q[SPREAD_ENA_BIT]) begin
            // Disabled: period and step play no part
            st_d  = FFSM_IDLE;
            cnt_d = '0;
            ofs_d = '0;
        end else begin
            case (st_q)
                FFSM_IDLE: begin
                    st_d = FFSM_DOWN;
                end
                FFSM_DOWN: begin
                    if (fb_tick) begin
                        // Clamp so the value never passes below zero
                        if (p_full - ofs_q < step_ext) ofs_d = p_full;
                        else                            ofs_d = ofs_q + step_ext;
                        cnt_d = ramp_end ? '0 : cnt_q + CNT_W'(1);
                        if (ramp_end) st_d = FFSM_UP;
                    end
                end
                FFSM_UP: begin
                    if (fb_tick) begin
                        // Offset never negative: value stays at or below P
                        if (ofs_q < step_ext) ofs_d = '0;
                        else                  ofs_d = ofs_q - step_ext;
                        cnt_d = ramp_end ? '0 : cnt_q + CNT_W'(1);
                        if (ramp_end) st_d = FFSM_DOWN;
                    end
                end
                default: begin
                    st_d  = FFSM_IDLE;
                    cnt_d = '0;
                    ofs_d = '0;
                end
            endcase
        end
        // Offset is clamped to P, so this never wraps
        mod_val = p_full - ofs_q;
        whole_d = mod_val[31:24];
        frac_d  = mod_val[23:0];
        total_d = {mod_val, 1'b0};
        dbl_d   = ref_ctrl_q[DOUBLER_ENA_BIT];
        // Settings below the floor would overdrive the output stage
        odo_d   = (odiv_q < OUT_DIV_MIN) ? OUT_DIV_MIN : odiv_q;
        act_d   = (st_d != FFSM_IDLE);
    end

    // Modulator flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q    <= FFSM_IDLE;
            cnt_q   <= '0;
            ofs_q   <= '0;
            whole_q <= RST_FB_INTEGER;
            frac_q  <= '0;
            total_q <= '0;
            dbl_q   <= 1'b0;
            odo_q   <= RST_OUT_DIV;
            act_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            ofs_q   <= ofs_d;
            whole_q <= whole_d;
            frac_q  <= frac_d;
            total_q <= total_d;
            dbl_q   <= dbl_d;
            odo_q   <= odo_d;
            act_q   <= act_d;
        end
    end

    // Outputs straight from flops
    assign prdata                 = rdata_q;
    assign pready                 = ready_q;
    assign pslverr                = err_q;
    assign divide_whole_part      = whole_q;
    assign divide_fractional_part = frac_q;
    assign fb_total_divide        = total_q;
    assign doubler_enable         = dbl_q;
    assign out_divide             = odo_q;
    assign spread_active          = act_q;
endmodule : ffsm_modulator

// ==== bench/ffsm_modulator_assertions.sv ====
// Port-level checker for the spread modulator
module ffsm_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Loop side
    input wire logic        fb_tick,
    input wire logic [7:0]  divide_whole_part,
    input wire logic [23:0] divide_fractional_part,
    input wire logic [32:0] fb_total_divide,
    input wire logic [11:0] out_divide,
    input wire logic        spread_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] quiet_q; // Edges since the last bus or tick activity
    logic [2:0] age_q;   // Edges since reset release, saturating
    // Both counters saturate so they never wrap into a false quiet span
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quiet_q <= 3'h0;
            age_q   <= 3'h0;
        end else begin
            quiet_q <= (psel || fb_tick) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            age_q   <= age_q + {2'h0, age_q != 3'h7};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    AST_ACCESS_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("No answer one cycle after access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("Ready held past one cycle");
    AST_ERR_READ_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("Refused transfer not clean");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("Read data upper bits set");
    AST_HIGH_ADDR_ERR: assert property (pready && paddr[11:10] != 2'h0 |-> pslverr)
        else $error("High address accepted");
    AST_DOUBLED: assert property (age_q >= 3'h2 |->
        fb_total_divide == {divide_whole_part, divide_fractional_part, 1'b0})
        else $error("Total divide not twice the value");
    AST_OUT_FLOOR: assert property (out_divide >= 12'h008)
        else $error("Output divider below eight");
    AST_STEP_PACE: assert property (quiet_q >= 3'h3 && !psel && !fb_tick |->
        $stable(divide_fractional_part) && $stable(divide_whole_part))
        else $error("Value moved without a time step");
    AST_ACTIVE_CAUSE: assert property (age_q >= 3'h4 && $changed(spread_active) |->
        $past(psel) || $past(psel, 2) || $past(psel, 3))
        else $error("Modulation state changed without a write");
endmodule : ffsm_chk

bind ffsm_modulator ffsm_chk u_chk (.core_clk, .resetn, .psel, .penable, .paddr, .prdata,
    .pready, .pslverr, .fb_tick, .divide_whole_part, .divide_fractional_part,
    .fb_total_divide, .out_divide, .spread_active);

// ==== bench/ffsm_loop_model.sv ====
// Loop stand-in giving one pulse per feedback divider output cycle
module ffsm_loop_model #(
    parameter int RATIO = 5 // Core clocks per divider cycle, short to keep runs brief
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Loop running
    input  wire logic run,
    // Divider output pulse
    output logic      fb_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_q; // Core clocks into the divider cycle
    // Silent while stopped, so no stray time steps reach the modulator
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q   <= 0;
            fb_tick <= 1'b0;
        end else begin
            cnt_q   <= (!run || cnt_q == RATIO - 1) ? 0 : cnt_q + 1;
            fb_tick <= run && cnt_q == RATIO - 1;
        end
    end
endmodule : ffsm_loop_model

// ==== bench/ffsm_modulator_tb.sv ====
// Self-checking bench for the spread modulator
module ffsm_modulator_tb
    import ffsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, resetn, psel, penable, pwrite, run, mon;
    logic [11:0] paddr, out_divide;
    logic [31:0] pwdata, prdata, mod_val, v_min, v_max; // Extremes while ramping
    logic        pready, pslverr, fb_tick, doubler_enable, spread_active;
    logic [7:0]  divide_whole_part;
    logic [23:0] divide_fractional_part;
    logic [32:0] fb_total_divide;
    int          n_fail, n_tests;
    assign mod_val = {divide_whole_part, divide_fractional_part};
    ffsm_modulator u_dut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fb_tick, .divide_whole_part, .divide_fractional_part,
        .fb_total_divide, .doubler_enable, .out_divide, .spread_active);
    ffsm_loop_model u_loop (.core_clk, .resetn, .run, .fb_tick);
    // Clock at 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Track extremes mid-cycle, where outputs are settled; cleared while not watching
    always @(negedge core_clk) begin
        if (!mon) begin
            v_min = 32'hFFFFFFFF;
            v_max = 32'h0;
        end
        if (mon && mod_val < v_min) v_min = mod_val;
        if (mon && mod_val > v_max) v_max = mod_val;
    end
    task automatic chk(input string nm, input logic [32:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer; the answer is taken at the rising edge where pready is high
    task automatic acc(input logic wr, input logic [9:0] ix, input logic [7:0] wd, exp,
                       input logic err);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {ix, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        // No assumed latency: only the watchdog ends a hang
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        if (!wr) chk("prdata", {1'b0, prdata}, {25'h0, exp});
        chk("pslverr", {32'h0, pslverr}, {32'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    // Reset contents, loop controls after reset, and refused places
    task automatic t_reset;
        logic [7:0] ix [8];
        logic [7:0] rv [8];
        ix = '{IDX_SPREAD_ENA_PER_HI, IDX_SPREAD_PER_LO, IDX_FB_INTEGER, IDX_FB_FRAC_HI,
               IDX_FB_FRAC_LO, IDX_SPREAD_STEP_HI, IDX_SPREAD_STEP_LO, IDX_REF_CTRL};
        rv = '{RST_SPREAD_ENA_PER_HI, RST_SPREAD_PER_LO, RST_FB_INTEGER, RST_FB_FRAC[15:8],
               RST_FB_FRAC[7:0], RST_SPREAD_STEP[15:8], RST_SPREAD_STEP[7:0], RST_REF_CTRL};
        foreach (ix[i]) acc(1'b0, ix[i], 8'h00, rv[i], 1'b0);
        acc(1'b0, 8'h40, 8'h00, 8'h00, 1'b1);
        acc(1'b1, 8'h40, 8'h5A, 8'h00, 1'b1);
        acc(1'b0, 10'h310, 8'h00, 8'h00, 1'b1);
        acc(1'b1, 10'h312, 8'h5A, 8'h00, 1'b1);
        acc(1'b0, IDX_FB_INTEGER, 8'h00, RST_FB_INTEGER, 1'b0);
        chk("total", fb_total_divide, {RST_FB_INTEGER, RST_FB_FRAC, 9'h000});
        chk("doubler", {32'h0, doubler_enable}, 33'h1);
        chk("outdiv", {21'h0, out_divide}, {21'h0, RST_OUT_DIV});
    endtask : t_reset
    // Static divide value, doubler off, output divider floor and top
    task automatic t_divide;
        acc(1'b1, IDX_SPREAD_ENA_PER_HI, 8'h00, 8'h00, 1'b0);
        acc(1'b1, IDX_FB_INTEGER, 8'h18, 8'h00, 1'b0);
        acc(1'b1, IDX_FB_FRAC_HI, 8'h93, 8'h00, 1'b0);
        acc(1'b1, IDX_FB_FRAC_LO, 8'h75, 8'h00, 1'b0);
        acc(1'b1, IDX_STATUS, 8'hFF, 8'h00, 1'b0);
        acc(1'b0, IDX_STATUS, 8'h00, 8'h00, 1'b0);
        acc(1'b1, IDX_REF_CTRL, 8'h4D, 8'h00, 1'b0);
        acc(1'b1, IDX_OUT_DIV_LO, 8'h03, 8'h00, 1'b0);
        acc(1'b0, IDX_FB_FRAC_HI, 8'h00, 8'h93, 1'b0);
        repeat (3) @(negedge core_clk);
        chk("total", fb_total_divide, 33'h03126EA00);
        chk("active", {32'h0, spread_active}, 33'h0);
        chk("doubler", {32'h0, doubler_enable}, 33'h0);
        chk("outdiv", {21'h0, out_divide}, 33'h008);
        acc(1'b1, IDX_OUT_DIV_HI, 8'hF0, 8'h00, 1'b0);
        acc(1'b1, IDX_OUT_DIV_LO, 8'hFF, 8'h00, 1'b0);
        repeat (3) @(negedge core_clk);
        chk("outdiv", {21'h0, out_divide}, 33'hFFF);
    endtask : t_divide
    // Ticks while disabled change nothing; enabled, a ramp of four steps each way
    task automatic t_spread;
        acc(1'b1, IDX_SPREAD_STEP_HI, 8'h01, 8'h00, 1'b0);
        acc(1'b1, IDX_SPREAD_STEP_LO, 8'h00, 8'h00, 1'b0);
        acc(1'b1, IDX_SPREAD_PER_LO, 8'h02, 8'h00, 1'b0);
        run <= 1'b1;
        repeat (40) @(negedge core_clk);
        chk("idle", {1'b0, mod_val}, 33'h018937500);
        acc(1'b1, IDX_SPREAD_ENA_PER_HI, 8'h80, 8'h00, 1'b0);
        mon <= 1'b1;
        repeat (170) @(negedge core_clk);
        chk("top", {1'b0, v_max}, 33'h018937500);
        chk("bottom", {1'b0, v_min}, 33'h018937100);
        chk("active", {32'h0, spread_active}, 33'h1);
        mon <= 1'b0;
        acc(1'b1, IDX_SPREAD_ENA_PER_HI, 8'h00, 8'h00, 1'b0);
        repeat (4) @(negedge core_clk);
        chk("off", {spread_active, mod_val}, 33'h018937500);
    endtask : t_spread
    task automatic conclude;
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Cut a hang short well past the expected run length
    initial begin
        #2000000;
        n_fail++;
        conclude;
    end
    initial begin
        {psel, penable, pwrite, run, mon} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        resetn = 1'b0;
        n_fail = 0;
        n_tests = 0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset;
        t_divide;
        t_spread;
        conclude;
    end
endmodule : ffsm_modulator_tb
